// [design/nv_write_map.vh]
// constants for the nonvolatile write controller
// assumes inclusion by bare name from the design file
`ifndef NV_WRITE_MAP_VH
`define NV_WRITE_MAP_VH
`define ADDR_NV_WRITE_CMD 8'hC9
`define ADDR_AUX_CONTROL_2 8'hF7
`define CMD_FLASH_ONE 8'h47
`define CMD_FLASH_TWO 8'h74
`define CMD_INFO 8'hA1
`define CMD_EEPROM 8'hE2
`define BIT_FLASH_WE 7
`define BIT_TIMEOUT 6
`define BIT_EEPROM_WE 5
`define BIT_INFO_WE 4
`define BIT_TSEL_HI 2
`define BIT_TSEL_LO 1
`define AUX_CONTROL_2_RESET 8'h06
`define TSEL_OFF 2'h0
`define TSEL_3MS 2'h1
`define TSEL_6MS 2'h2
`define TSEL_25MS 2'h3
`define FLASH_LAST 16'h3FFE
`define EEPROM_BASE 16'hEE00
`define EEPROM_LAST 16'hEEFE
`define INFO_BASE 16'hE500
`define INFO_LAST 16'hE53F
`define INFO_BOOT_BASE 16'hE520
`define TIME_3MS_US 3000
`define TIME_6MS_US 6000
`define TIME_25MS_US 25000
`define TIME_EEPROM_US 1000
`define TIME_FLASH_US 1000
`define TIME_INFO_US 600
`define TIME_READ_NS 300
`define CLK_MHZ 100
`define NS_ROUND 999
`define NS_PER_US 1000
`endif

// [design/nv_write_controller.v]
// write control for flash self-programming, eeprom and info memory
// assumes an 8051 core on clk issuing sfr and external-data accesses
// Functional notes
// - 47h/74h set flash enable, else clear
// - A1h sets info enable, else clear
// - E2h sets eeprom enable, else clear
// - command read bit7 is flash enable
// - bit5 eeprom enable, bit4 info enable
// - timeout flag bit6 set on overrun
// - timeout flag cleared by any command write
// - aux bits 2:1 select timeout, reset 11
// - timeout abandons write, releases cpu
// - one timeout shared by all writes
// - 128 eeprom bytes, byte access
// - eeprom at even EE00h..EEFEh only
// - enabled eeprom store programs accumulator byte
// - cpu waits during write, peripherals run
// - eeprom load returns byte, about 300ns
// - 64 byte info memory E500h..E53Fh
// - info writes only boot area, enabled
// - info write takes about 0.6ms
// - flash store 0000h..3FFEh when enabled
`timescale 1ns/10ps
`include "nv_write_map.vh"
module nv_write_controller #(
  parameter T3_CYC = `TIME_3MS_US * `CLK_MHZ, // 3 ms in cycles
  parameter T6_CYC = `TIME_6MS_US * `CLK_MHZ, // 6 ms in cycles
  parameter T25_CYC = `TIME_25MS_US * `CLK_MHZ, // 25 ms in cycles
  parameter EE_PROG_CYC = `TIME_EEPROM_US * `CLK_MHZ, // eeprom program time
  parameter FL_PROG_CYC = `TIME_FLASH_US * `CLK_MHZ, // flash program time
  parameter INFO_PROG_CYC = `TIME_INFO_US * `CLK_MHZ // info program time
)(
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_ff,
  input wire [15:0] xd_addr,
  input wire xd_wr,
  input wire xd_rd,
  input wire [7:0] xd_wdata,
  output reg [7:0] xd_rdata_ff,
  output reg xd_rvalid_ff,
  output reg cpu_wait_ff,
  output reg flash_prog_ff,
  output reg [15:0] flash_addr_ff,
  output reg [7:0] flash_data_ff,
  input wire flash_done
);
  // read access time rounded up to whole cycles
  localparam integer READ_CYC_I = (`TIME_READ_NS * `CLK_MHZ + `NS_ROUND) / `NS_PER_US;
  // five bits hold the 30-cycle eeprom access at 100 MHz
  localparam [4:0] READ_CYC = READ_CYC_I[4:0];
  // sequencer states
  localparam [1:0] ST_IDLE = 2'h0; // no write
  localparam [1:0] ST_PROG = 2'h1; // programming, cpu held
  localparam [1:0] ST_DONE = 2'h2; // releasing cpu
  // address classes from the region decoder
  localparam [1:0] RGN_NONE = 2'h0; // not ours
  localparam [1:0] RGN_FLASH = 2'h1; // program flash
  localparam [1:0] RGN_EEPROM = 2'h2; // even eeprom byte
  localparam [1:0] RGN_INFO = 2'h3; // info memory
  // write targets held while programming
  localparam [1:0] TGT_FLASH = 2'h0; // flash engine
  localparam [1:0] TGT_EEPROM = 2'h1; // eeprom array
  localparam [1:0] TGT_INFO = 2'h2; // info array

  // control and status flags
  reg flash_we_ff; // flash write enable
  reg flash_two_ff; // two-byte flash mode
  reg eeprom_we_ff; // eeprom write enable
  reg info_we_ff; // info write enable
  reg timeout_ff; // write timeout flag
  reg [7:0] aux_control_2_ff; // auxiliary control
  // sequencer and counters
  reg [1:0] state_ff; // write sequencer
  reg [1:0] target_ff; // 0 flash 1 eeprom 2 info
  reg [31:0] prog_cnt_ff; // programming time
  reg [31:0] tmo_cnt_ff; // timeout time
  reg [31:0] tmo_lim_ff; // timeout limit latched at start
  reg [6:0] ee_idx_ff; // eeprom byte index
  reg [5:0] info_idx_ff; // info byte index
  reg [7:0] wr_data_ff; // byte to store
  reg [4:0] rd_cnt_ff; // eeprom read delay
  reg rd_busy_ff; // eeprom read pending
  // storage arrays, flip-flops indexed by byte
  reg [7:0] eeprom_mem [0:127]; // eeprom storage
  reg [7:0] info_mem [0:63]; // info storage

  // address class decoder
  // shared by the store path and the load path
  function [1:0] region;
    input [15:0] a;
    begin
      // flash stores run up to and include the last word at 3FFEh
      if (a <= `FLASH_LAST)
        region = RGN_FLASH;
      // odd eeprom addresses fall through as invalid
      else if (a >= `EEPROM_BASE && a <= `EEPROM_LAST && !a[0])
        region = RGN_EEPROM;
      else if (a >= `INFO_BASE && a <= `INFO_LAST)
        region = RGN_INFO;
      else
        region = RGN_NONE;
    end
  endfunction

  wire [1:0] wr_region = region(xd_addr); // store target class
  wire [1:0] rd_region = region(xd_addr); // load source class
  wire [1:0] tsel = aux_control_2_ff[`BIT_TSEL_HI:`BIT_TSEL_LO]; // timeout select
  wire cmd_wr = sfr_wr && sfr_addr == `ADDR_NV_WRITE_CMD; // command write
  // accepted store: area writable and enable set
  // a refused store never raises the wait
  wire fl_go = wr_region == RGN_FLASH && flash_we_ff;
  wire ee_go = wr_region == RGN_EEPROM && eeprom_we_ff;
  // the factory area below the boot area stays read-only
  wire in_go = wr_region == RGN_INFO && info_we_ff && xd_addr >= `INFO_BOOT_BASE;
  // stores while busy are dropped
  wire start = state_ff == ST_IDLE && xd_wr && (fl_go || ee_go || in_go);
  // timeout compares against the limit latched at start
  wire tmo_hit = state_ff == ST_PROG && tsel != `TSEL_OFF && tmo_cnt_ff >= tmo_lim_ff;
  // flash finishes on the engine's done, arrays on the local count
  wire prog_end = state_ff == ST_PROG &&
    (target_ff == TGT_FLASH ? flash_done : prog_cnt_ff == 32'h0);

  // enable flags, timeout flag and aux register
  // every command write rewrites all three enables at once
  // the timeout flag falls with any command write, but a
  // timeout arriving in that same cycle still sets it
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flash_we_ff <= 1'b0;
      flash_two_ff <= 1'b0;
      eeprom_we_ff <= 1'b0;
      info_we_ff <= 1'b0;
      timeout_ff <= 1'b0;
      aux_control_2_ff <= `AUX_CONTROL_2_RESET;
    end
    else if (ce)
    begin
      if (cmd_wr)
      begin
        // every write decodes all three flags
        flash_we_ff <= sfr_wdata == `CMD_FLASH_ONE || sfr_wdata == `CMD_FLASH_TWO;
        flash_two_ff <= sfr_wdata == `CMD_FLASH_TWO;
        info_we_ff <= sfr_wdata == `CMD_INFO;
        eeprom_we_ff <= sfr_wdata == `CMD_EEPROM;
      end
      // aux register is plain read/write
      if (sfr_wr && sfr_addr == `ADDR_AUX_CONTROL_2)
        aux_control_2_ff <= sfr_wdata;
      // set beats clear in the same cycle
      if (tmo_hit)
        timeout_ff <= 1'b1;
      else if (cmd_wr)
        timeout_ff <= 1'b0;
    end
  end

  // sfr read data
  // low command bits and unmapped addresses read zero
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      sfr_rdata_ff <= 8'h00;
    else if (ce && sfr_rd)
    begin
      if (sfr_addr == `ADDR_NV_WRITE_CMD)
        sfr_rdata_ff <= {flash_we_ff, timeout_ff, eeprom_we_ff, info_we_ff, 4'h0};
      else if (sfr_addr == `ADDR_AUX_CONTROL_2)
        sfr_rdata_ff <= aux_control_2_ff;
      else
        sfr_rdata_ff <= 8'h00;
    end
  end

  // write sequencer with shared timeout
  // idle: a refused or busy store is dropped without a stall
  // prog: cpu held, program and timeout counted side by side
  // done: one cycle to drop the wait, then idle again
  // the limit is latched at start; a select change mid-write
  // only matters when it turns timing off, or on with the 25 ms limit
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      target_ff <= 2'h0;
      prog_cnt_ff <= 32'h0;
      tmo_cnt_ff <= 32'h0;
      tmo_lim_ff <= 32'h0;
      cpu_wait_ff <= 1'b0;
      flash_prog_ff <= 1'b0;
      flash_addr_ff <= 16'h0000;
      flash_data_ff <= 8'h00;
      ee_idx_ff <= 7'h00;
      info_idx_ff <= 6'h00;
      wr_data_ff <= 8'h00;
    end
    else if (ce)
    begin
      case (state_ff)
        ST_IDLE:
        begin
          flash_prog_ff <= 1'b0;
          if (start)
          begin
            state_ff <= ST_PROG;
            cpu_wait_ff <= 1'b1;
            tmo_cnt_ff <= 32'h0;
            // one limit serves every target
            if (tsel == `TSEL_3MS)
              tmo_lim_ff <= T3_CYC;
            else if (tsel == `TSEL_6MS)
              tmo_lim_ff <= T6_CYC;
            else
              tmo_lim_ff <= T25_CYC;
            wr_data_ff <= xd_wdata;
            ee_idx_ff <= xd_addr[7:1];
            info_idx_ff <= xd_addr[5:0];
            // pick the target; flash gets a one-cycle program pulse
            if (fl_go)
            begin
              target_ff <= TGT_FLASH;
              flash_prog_ff <= 1'b1;
              flash_addr_ff <= xd_addr;
              flash_data_ff <= xd_wdata;
              prog_cnt_ff <= FL_PROG_CYC;
            end
            else if (ee_go)
            begin
              // eeprom program time counted locally
              target_ff <= TGT_EEPROM;
              prog_cnt_ff <= EE_PROG_CYC;
            end
            else
            begin
              // info program time counted locally
              target_ff <= TGT_INFO;
              prog_cnt_ff <= INFO_PROG_CYC;
            end
          end
        end
        ST_PROG:
        begin
          // count both the program time and the timeout
          flash_prog_ff <= 1'b0;
          tmo_cnt_ff <= tmo_cnt_ff + 32'h1;
          if (prog_cnt_ff != 32'h0)
            prog_cnt_ff <= prog_cnt_ff - 32'h1;
          // timeout wins over a finish in the same cycle
          if (tmo_hit)
            state_ff <= ST_DONE;
          else if (prog_end)
            state_ff <= ST_DONE;
        end
        ST_DONE:
        begin
          // drop the wait, cpu resumes next cycle
          cpu_wait_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // storage update on normal completion only
  // a timed-out write leaves the old byte in place
  always @(posedge clk)
  begin
    if (ce && prog_end && !tmo_hit)
    begin
      if (target_ff == TGT_EEPROM)
        eeprom_mem[ee_idx_ff] <= wr_data_ff;
      else if (target_ff == TGT_INFO)
        info_mem[info_idx_ff] <= wr_data_ff;
      // flash data leaves through the engine ports
    end
  end

  // external-data reads of eeprom and info
  // eeprom data is latched at once, valid pulses after the access time
  // info data needs no wait, so it is valid the next cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xd_rdata_ff <= 8'h00;
      xd_rvalid_ff <= 1'b0;
      rd_busy_ff <= 1'b0;
      rd_cnt_ff <= 5'h00;
    end
    else if (ce)
    begin
      // valid is a one-cycle pulse
      xd_rvalid_ff <= 1'b0;
      if (rd_busy_ff)
      begin
        // loads during a pending eeprom read are not answered
        if (rd_cnt_ff <= 5'h01)
        begin
          rd_busy_ff <= 1'b0;
          xd_rvalid_ff <= 1'b1;
        end
        else
          rd_cnt_ff <= rd_cnt_ff - 5'h01;
      end
      else if (xd_rd)
      begin
        if (rd_region == RGN_EEPROM)
        begin
          // even address, byte index from bits 7:1
          xd_rdata_ff <= eeprom_mem[xd_addr[7:1]];
          rd_busy_ff <= 1'b1;
          rd_cnt_ff <= READ_CYC;
        end
        else if (rd_region == RGN_INFO)
        begin
          // info reads take no wait states
          xd_rdata_ff <= info_mem[xd_addr[5:0]];
          xd_rvalid_ff <= 1'b1;
        end
        // other loads belong to other blocks, no answer here
      end
    end
  end
endmodule

// [bench/nv_write_controller_monitor.sv]
// port checker for the nv write controller
// assumes bind onto the design top, one clock
`timescale 1ns/10ps
module nv_write_controller_monitor #(
  parameter T25_CYC = 100
)(
  input wire clk,
  input wire rst,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_rdata_ff,
  input wire [15:0] xd_addr,
  input wire xd_wr,
  input wire xd_rd,
  input wire xd_rvalid_ff,
  input wire cpu_wait_ff,
  input wire flash_prog_ff
);
  reg [15:0] wait_cnt_ff; // stall length so far
  wire idle_st = !cpu_wait_ff && xd_wr; // store taken while idle
  // count stalled cycles
  always @(posedge clk or posedge rst)
    if (rst)
      wait_cnt_ff <= 16'h0000;
    else
      wait_cnt_ff <= cpu_wait_ff ? wait_cnt_ff + 16'h0001 : 16'h0000;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  stall_cause_a: assert property ($rose(cpu_wait_ff) |-> $past(xd_wr)) else $error("stall no store");
  stall_bound_a: assert property (wait_cnt_ff < T25_CYC + 16) else $error("stall too long");
  odd_ee_a: assert property (idle_st && xd_addr[15:8] == 8'hEE && xd_addr[0] |=> !cpu_wait_ff)
    else $error("odd store");
  info_prot_a: assert property (idle_st && xd_addr >= 16'hE500 && xd_addr < 16'hE520 |=> !cpu_wait_ff)
    else $error("factory store");
  prog_pulse_a: assert property (flash_prog_ff |-> cpu_wait_ff ##1 !flash_prog_ff) else $error("prog");
  ee_read_a: assert property (xd_rd && xd_addr[15:8] == 8'hEE && !xd_addr[0] |-> ##[30:32] xd_rvalid_ff)
    else $error("ee read");
  info_read_a: assert property (xd_rd && xd_addr >= 16'hE500 && xd_addr <= 16'hE53F |=> xd_rvalid_ff)
    else $error("info read");
  cmd_low_a: assert property (sfr_rd && sfr_addr == 8'hC9 |=> sfr_rdata_ff[3:0] == 4'h0) else $error("low bits");
endmodule
bind nv_write_controller nv_write_controller_monitor #(.T25_CYC(T25_CYC)) u_nv_write_controller_monitor (
  .clk(clk), .rst(rst), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_rdata_ff(sfr_rdata_ff), .xd_addr(xd_addr),
  .xd_wr(xd_wr), .xd_rd(xd_rd), .xd_rvalid_ff(xd_rvalid_ff), .cpu_wait_ff(cpu_wait_ff),
  .flash_prog_ff(flash_prog_ff));

// [bench/flash_engine_model.sv]
// flash programming engine answering program pulses
// assumes pulses on clk; slow holds it 200 cycles, past the bench's 3 ms and 25 ms limits
`timescale 1ns/10ps
module flash_engine_model #(
  parameter PROG_CYC = 10
)(
  input wire clk,
  input wire rst,
  input wire flash_prog_ff,
  input wire slow,
  output reg flash_done
);
  reg [8:0] left_ff; // cycles to done, 0 idle
  // load on a pulse, count down, one-cycle done
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      left_ff <= 9'h000;
      flash_done <= 1'b0;
    end
    else
    begin
      flash_done <= (left_ff == 9'h001);
      if (flash_prog_ff)
        left_ff <= slow ? 9'h0C8 : 9'(PROG_CYC);
      else if (left_ff != 9'h000)
        left_ff <= left_ff - 9'h001;
    end
endmodule

// [bench/nv_write_controller_tb.sv]
// self-checking bench, bench acts as the cpu
// assumes shortened timing parameters
`timescale 1ns/10ps
module nv_write_controller_tb;
  reg clk, rst, sfr_wr, sfr_rd, xd_wr, xd_rd, slow, prev_rd;
  reg [7:0] sfr_addr, sfr_wdata, xd_wdata, d, e;
  reg [15:0] xd_addr;
  wire [7:0] sfr_rdata_ff, xd_rdata_ff, flash_data_ff;
  wire [15:0] flash_addr_ff;
  wire xd_rvalid_ff, cpu_wait_ff, flash_prog_ff, flash_done;
  integer failures, checks_done, seed, i, k;
  reg [7:0] exp_q[$]; // expected read data
  reg [7:0] cmd_t[0:4]; // command codes
  reg [7:0] bit_t[0:4]; // expected readback
  nv_write_controller #(.T3_CYC(40), .T25_CYC(100), .EE_PROG_CYC(10),
    .INFO_PROG_CYC(8)) u_nv_write_controller (.clk(clk), .rst(rst), .ce(1'b1), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_ff(sfr_rdata_ff), .xd_addr(xd_addr),
    .xd_wr(xd_wr), .xd_rd(xd_rd), .xd_wdata(xd_wdata), .xd_rdata_ff(xd_rdata_ff), .xd_rvalid_ff(xd_rvalid_ff),
    .cpu_wait_ff(cpu_wait_ff), .flash_prog_ff(flash_prog_ff), .flash_addr_ff(flash_addr_ff),
    .flash_data_ff(flash_data_ff), .flash_done(flash_done));
  flash_engine_model u_flash_engine_model (.clk(clk), .rst(rst),
    .flash_prog_ff(flash_prog_ff), .slow(slow), .flash_done(flash_done));
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input [47:0] nm, input [15:0] ex, input [15:0] got);
  begin
    checks_done = checks_done + 1;
    if (got !== ex)
    begin
      failures = failures + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, ex, got);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // bounded wait for idle and no pending note
  task settle;
  begin
    for (i = 0; i < 400 && (cpu_wait_ff !== 1'b0 || exp_q.size() > 0); i = i + 1)
      @(negedge clk);
    if (i == 400)
    begin
      failures = failures + 1;
      print_verdict;
    end
  end
  endtask
  task sfr(input w, input [7:0] a, input [7:0] v);
  begin
    if (!w)
      exp_q.push_back(v);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = w;
    sfr_rd = !w;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    @(negedge clk);
    settle;
  end
  endtask
  task xd(input w, input [15:0] a, input [7:0] v);
  begin
    if (!w)
      exp_q.push_back(v);
    @(negedge clk);
    xd_addr = a;
    xd_wdata = v;
    xd_wr = w;
    xd_rd = !w;
    @(negedge clk);
    xd_wr = 1'b0;
    xd_rd = 1'b0;
    @(negedge clk);
    settle;
  end
  endtask
  // remember a register read
  always @(posedge clk)
    prev_rd <= sfr_rd;
  // take the oldest note when data shows up
  always @(negedge clk)
    if (prev_rd === 1'b1 || xd_rvalid_ff === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("extra", 16'h0000, 16'h0001);
      else
        chk("rdata", exp_q.pop_front(), prev_rd ? sfr_rdata_ff : xd_rdata_ff);
    end
  // main sequence
  initial
  begin
    {rst, sfr_wr, sfr_rd, xd_wr, xd_rd, slow} = 6'h20;
    {sfr_addr, sfr_wdata, xd_wdata, xd_addr} = 40'h0;
    failures = 0;
    checks_done = 0;
    seed = 6698;
    d = $random(seed);
    e = ~d;
    cmd_t[0] = 8'h47; cmd_t[1] = 8'h74; cmd_t[2] = 8'hA1; cmd_t[3] = 8'hE2; cmd_t[4] = {2'b00, d[5:0]};
    bit_t[0] = 8'h80; bit_t[1] = 8'h80; bit_t[2] = 8'h10; bit_t[3] = 8'h20; bit_t[4] = 8'h00;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    sfr(0, 8'hC9, 8'h00);
    sfr(0, 8'hF7, 8'h06);
    for (k = 0; k < 5; k = k + 1)
    begin
      sfr(1, 8'hC9, cmd_t[k]);
      sfr(0, 8'hC9, bit_t[k]);
    end
    sfr(1, 8'hC9, 8'hE2);
    xd(1, 16'hEE04, d);
    xd(1, 16'hEEFE, e);
    xd(1, 16'hEE05, e);
    xd(0, 16'hEE04, d);
    xd(0, 16'hEEFE, e);
    sfr(1, 8'hC9, 8'h00);
    xd(1, 16'hEE04, e);
    xd(0, 16'hEE04, d);
    sfr(1, 8'hC9, 8'hA1);
    xd(1, 16'hE530, d);
    xd(1, 16'hE51F, e);
    xd(0, 16'hE530, d);
    sfr(1, 8'hC9, 8'h47);
    xd(1, 16'h3F00, e);
    chk("faddr", 16'h3F00, flash_addr_ff);
    chk("fdata", {8'h00, e}, flash_data_ff);
    sfr(1, 8'hF7, 8'h02);
    sfr(0, 8'hF7, 8'h02);
    slow = 1'b1;
    xd(1, 16'h3F10, d);
    sfr(0, 8'hC9, 8'hC0);
    sfr(1, 8'hC9, 8'h47);
    sfr(0, 8'hC9, 8'h80);
    print_verdict;
  end
endmodule
